// ===== hdl/ulsr_pkg.sv
package ulsr_pkg;

  // bus geometry
  localparam int HADDR_W = 32;
  localparam int HDATA_W = 32;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // register map, byte addresses
  localparam logic [HADDR_W-1:0] OFF_LSTAT = 32'h0000_0000;
  localparam logic [HADDR_W-1:0] OFF_ISR  = 32'h0000_0004;
  localparam logic [HADDR_W-1:0] OFF_IMR  = 32'h0000_0008;
  localparam logic [HADDR_W-1:0] OFF_CTRL = 32'h0000_000c;

  // line_status bit positions
  localparam int LS_W    = 8;
  localparam int LS_RDY  = 0;
  localparam int LS_OVR  = 1;
  localparam int LS_PAR  = 2;
  localparam int LS_FRM  = 3;
  localparam int LS_BRK  = 4;
  localparam int LS_THRE = 5;
  localparam int LS_TEMT = 6;
  localparam int LS_FERR = 7;

  // per-character error tag carried beside the receive fifo
  localparam int FL_W   = 3;
  localparam int FL_PAR = 0;
  localparam int FL_FRM = 1;
  localparam int FL_BRK = 2;

  // interrupt status / mask layout
  localparam int IS_W    = 4;
  localparam int IS_THRE = 0;
  localparam int IS_RDY  = 1;
  localparam int IS_LERR = 2;
  localparam int IS_OVR  = 3;
  localparam logic [IS_W-1:0] IS_RESET = 4'h0;

  // control register layout
  localparam int CT_W       = 5;
  localparam int CT_FIFO    = 0;
  localparam int CT_WLEN_LO = 1;
  localparam int CT_WLEN_HI = 2;
  localparam int CT_PAR     = 3;
  localparam int CT_STOP2   = 4;
  localparam logic [CT_W-1:0] CT_RESET = 5'h06;

  // frame length arithmetic, in bit times
  localparam int FRAME_W = 4;
  localparam logic [FRAME_W-1:0] FRAME_BASE = 4'h7;

  typedef enum {ULSR_SEL_LSTAT, ULSR_SEL_ISR, ULSR_SEL_IMR, ULSR_SEL_CTRL,
                ULSR_SEL_NONE} ulsr_sel_t;

  function automatic ulsr_sel_t ulsr_decode(input logic [HADDR_W-1:0] addr);
    case (addr)
      OFF_LSTAT: ulsr_decode = ULSR_SEL_LSTAT;
      OFF_ISR:  ulsr_decode = ULSR_SEL_ISR;
      OFF_IMR:  ulsr_decode = ULSR_SEL_IMR;
      OFF_CTRL: ulsr_decode = ULSR_SEL_CTRL;
      default:  ulsr_decode = ULSR_SEL_NONE;
    endcase
  endfunction : ulsr_decode

  // start + 5..8 data + optional parity + 1 or 2 stop
  function automatic logic [FRAME_W-1:0] ulsr_frame_len(input logic [CT_W-1:0] ct);
    ulsr_frame_len = FRAME_BASE + FRAME_W'(ct[CT_WLEN_HI:CT_WLEN_LO])
                     + FRAME_W'(ct[CT_PAR]) + FRAME_W'(ct[CT_STOP2]);
  endfunction : ulsr_frame_len

endpackage : ulsr_pkg

// ===== hdl/ulsr_err_track.sv
module ulsr_err_track
  import ulsr_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic            clk_sys,   // system clock
  input  wire logic            nrst,      // async reset, active low
  input  wire logic            push,      // store tag of new character
  input  wire logic [FL_W-1:0] tag_in,    // tag of new character
  input  wire logic            pop,       // head character removed
  input  wire logic [CW-1:0]   cap,       // usable depth in this mode
  output logic      [CW-1:0]   count,     // characters held
  output logic                 full,      // count reached cap
  output logic      [FL_W-1:0] head_tag,  // tag of head character
  output logic                 any_err    // some held character is tagged
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [FL_W-1:0] tags [DEPTH];
  logic [PW-1:0]   wr_ptr;
  logic [PW-1:0]   rd_ptr;
  logic [CW-1:0]   err_cnt;
  logic            do_push;
  logic            do_pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : ptr_inc

  assign full     = (count >= cap);
  assign do_pop   = pop && (count != '0);
  assign do_push  = push && (!full || do_pop);
  assign head_tag = (count != '0) ? tags[rd_ptr] : '0;
  assign any_err  = (err_cnt != '0);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) wr_ptr <= ptr_inc(wr_ptr);
      if (do_pop) rd_ptr <= ptr_inc(rd_ptr);
      count <= count + CW'(do_push) - CW'(do_pop);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      err_cnt <= '0;
    end else begin
      err_cnt <= err_cnt + CW'(do_push && (tag_in != '0))
                 - CW'(do_pop && (tags[rd_ptr] != '0));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (do_push) tags[wr_ptr] <= tag_in;
  end

endmodule : ulsr_err_track

// ===== hdl/ulsr_line_status.sv
// Local design decisions: the AHB-Lite slave port and the address map.
module ulsr_line_status
  import ulsr_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic               clk_sys,        // system clock
  input  wire logic               nrst,           // async reset, active low
  input  wire logic               hsel,           // slave select
  input  wire logic [HADDR_W-1:0] haddr,          // byte address
  input  wire logic [1:0]         htrans,         // transfer type
  input  wire logic               hwrite,         // write when high
  input  wire logic [2:0]         hsize,          // word only
  input  wire logic [HDATA_W-1:0] hwdata,         // write data
  input  wire logic               hready,         // bus ready
  output logic                    hreadyout,      // always ready
  output logic                    hresp,          // always okay
  output logic      [HDATA_W-1:0] hrdata,         // read data
  input  wire logic               rx_line,        // receive input level
  input  wire logic               rx_bit_tick,    // one pulse per bit time
  input  wire logic               rx_char_done,   // receiver finished a character
  input  wire logic               rx_parity_bad,  // parity mismatch of that character
  input  wire logic               rx_stop_level,  // line level at stop position
  input  wire logic               rx_pop,         // host took the head character
  output logic                    rx_push,        // store character into receive fifo
  output logic                    rx_push_brk,    // stored character is a break
  input  wire logic               hold_write,     // host writes transmit character
  input  wire logic               tx_shift_load,  // character moves into shift stage
  input  wire logic               tx_shift_done,  // shift stage finished sending
  output logic                    irq             // level interrupt
);

  localparam int CW = $clog2(FIFO_DEPTH + 1);

  logic [CT_W-1:0]    ctrl;
  logic [IS_W-1:0]    int_status;
  logic [IS_W-1:0]    int_mask;
  logic               ap_take;
  logic               dp_wr;
  ulsr_sel_t          dp_sel;
  ulsr_sel_t          ap_sel;
  logic               ls_read;
  logic               fifo_mode;
  logic [CW-1:0]      cap;
  logic [LS_W-1:0]    ls_now;
  logic               fifo_err;
  logic               ovr;
  logic [FRAME_W-1:0] brk_cnt;
  logic               brk_active;
  logic               brk_hit;
  logic               char_in;
  logic [FL_W-1:0]    push_tag;
  logic               ovr_evt;
  logic               push_ok;
  logic               pop_ok;
  logic [CW-1:0]      rx_cnt;
  logic               rx_full;
  logic [FL_W-1:0]    head_tag;
  logic               any_err;
  logic [CW-1:0]      tx_cnt;
  logic               shift_busy;
  logic               wr_ok;
  logic               thre;
  logic               temt;
  logic [IS_W-1:0]    is_set;
  logic [IS_W-1:0]    next_int_status;

  assign fifo_mode = ctrl[CT_FIFO];
  assign cap       = fifo_mode ? CW'(FIFO_DEPTH) : CW'(1);

  // bus slave: zero wait states, okay only
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign ap_take   = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign ap_sel    = ulsr_decode(haddr);
  assign ls_read   = ap_take && !hwrite && (ap_sel == ULSR_SEL_LSTAT);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dp_wr  <= 1'b0;
      dp_sel <= ULSR_SEL_NONE;
    end else begin
      dp_wr  <= ap_take && hwrite;
      dp_sel <= ap_sel;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hrdata <= '0;
    end else if (ap_take && !hwrite) begin
      case (ap_sel)
        ULSR_SEL_LSTAT: hrdata <= HDATA_W'(ls_now);
        ULSR_SEL_ISR:  hrdata <= HDATA_W'(int_status);
        ULSR_SEL_IMR:  hrdata <= HDATA_W'(int_mask);
        ULSR_SEL_CTRL: hrdata <= HDATA_W'(ctrl);
        default:       hrdata <= '0;
      endcase
    end
  end

  // line_status holds no writable field
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl     <= CT_RESET;
      int_mask <= '0;
    end else if (dp_wr) begin
      case (dp_sel)
        ULSR_SEL_IMR:  int_mask <= hwdata[IS_W-1:0];
        ULSR_SEL_CTRL: ctrl <= hwdata[CT_W-1:0];
        default:       ctrl <= ctrl;
      endcase
    end
  end

  // break: receive input low for a whole frame, one break character per break
  assign brk_hit = rx_bit_tick && !rx_line && !brk_active
                   && (brk_cnt == ulsr_frame_len(ctrl) - FRAME_W'(1));

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      brk_cnt    <= '0;
      brk_active <= 1'b0;
    end else if (rx_line) begin
      brk_cnt    <= '0;
      brk_active <= 1'b0;
    end else if (brk_hit) begin
      brk_cnt    <= '0;
      brk_active <= 1'b1;
    end else if (rx_bit_tick && !brk_active) begin
      brk_cnt <= brk_cnt + FRAME_W'(1);
    end
  end

  // receive side tagging
  assign char_in = (rx_char_done && !brk_active) || brk_hit;

  always_comb begin
    push_tag         = '0;
    push_tag[FL_PAR] = rx_char_done && !brk_hit && rx_parity_bad;
    push_tag[FL_FRM] = brk_hit || !rx_stop_level;
    push_tag[FL_BRK] = brk_hit;
  end

  assign ovr_evt     = char_in && rx_full && !(rx_pop && rx_cnt != '0);
  assign push_ok     = char_in && !ovr_evt;
  assign pop_ok      = rx_pop && (rx_cnt != '0);
  assign rx_push     = push_ok;
  assign rx_push_brk = push_ok && brk_hit;

  ulsr_err_track #(
    .DEPTH (FIFO_DEPTH),
    .CW    (CW)
  ) u_track (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .push     (push_ok),
    .tag_in   (push_tag),
    .pop      (rx_pop),
    .cap      (cap),
    .count    (rx_cnt),
    .full     (rx_full),
    .head_tag (head_tag),
    .any_err  (any_err)
  );

  // aggregate error: set wins over the read clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fifo_err <= 1'b0;
    end else if (push_ok && (push_tag != '0)) begin
      fifo_err <= 1'b1;
    end else if (ls_read || !any_err) begin
      fifo_err <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ovr <= 1'b0;
    end else if (ovr_evt) begin
      ovr <= 1'b1;
    end else if (ls_read) begin
      ovr <= 1'b0;
    end
  end

  // transmit occupancy: holding stage or fifo, plus shift stage
  assign wr_ok = hold_write && (tx_cnt < cap || tx_shift_load);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_cnt <= '0;
    end else begin
      tx_cnt <= tx_cnt + CW'(wr_ok) - CW'(tx_shift_load && tx_cnt != '0);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shift_busy <= 1'b0;
    end else if (tx_shift_load && tx_cnt != '0) begin
      shift_busy <= 1'b1;
    end else if (tx_shift_done) begin
      shift_busy <= 1'b0;
    end
  end

  assign thre = (tx_cnt == '0) && !hold_write;
  assign temt = thre && !shift_busy;

  always_comb begin
    ls_now          = '0;
    ls_now[LS_RDY]  = (rx_cnt != '0);
    ls_now[LS_OVR]  = ovr;
    ls_now[LS_PAR]  = head_tag[FL_PAR];
    ls_now[LS_FRM]  = head_tag[FL_FRM];
    ls_now[LS_BRK]  = head_tag[FL_BRK];
    ls_now[LS_THRE] = thre;
    ls_now[LS_TEMT] = temt;
    ls_now[LS_FERR] = fifo_err;
  end

  // interrupt status: set wins over write-one-to-clear
  always_comb begin
    is_set          = '0;
    is_set[IS_THRE] = thre;
    is_set[IS_RDY]  = push_ok;
    is_set[IS_LERR] = (push_ok && push_tag != '0) || ovr_evt;
    is_set[IS_OVR]  = ovr_evt;
    next_int_status = int_status;
    if (dp_wr && dp_sel == ULSR_SEL_ISR) begin
      next_int_status = int_status & ~hwdata[IS_W-1:0];
    end
    next_int_status = next_int_status | is_set;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      int_status <= IS_RESET;
      irq        <= 1'b0;
    end else begin
      int_status <= next_int_status;
      irq        <= |(int_status & int_mask);
    end
  end

  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  chk_ferr_set: assert property (push_ok && push_tag != '0 |=> fifo_err)
    else $error("fifo error flag not set by tagged character");
  chk_ferr_read_clear: assert property (
    ls_read && !(push_ok && push_tag != '0) |=> !fifo_err)
    else $error("fifo error flag survived line_status read");
  chk_temt_idle: assert property (
    tx_shift_done && tx_cnt == '0 && !tx_shift_load && !hold_write
    |=> (tx_cnt == '0) && !shift_busy)
    else $error("transmitter not empty after shift finished");
  chk_thre_load: assert property (
    tx_shift_load && tx_cnt == CW'(1) && !hold_write |=> tx_cnt == '0)
    else $error("holding stage not emptied by load");
  chk_thre_write: assert property (hold_write |-> !ls_now[LS_THRE] && !ls_now[LS_TEMT])
    else $error("holding empty shown during host write");
  chk_irq_thre: assert property (
    thre && int_mask[IS_THRE] && !dp_wr && !(ap_take && hwrite) |-> ##2 irq)
    else $error("transmit empty interrupt missing");
  chk_break_once: assert property (brk_hit |=> brk_active && !brk_hit)
    else $error("second break character in one break");
  chk_break_len: assert property (
    brk_hit |-> !rx_line && !$past(rx_line) && brk_cnt != '0)
    else $error("break flagged before a whole frame");
  chk_overrun_flag: assert property (ovr_evt |=> ovr && rx_cnt == $past(rx_cnt))
    else $error("overrun not flagged or fifo disturbed");
  chk_ready_drop: assert property (
    pop_ok && rx_cnt == CW'(1) && !push_ok |=> !ls_now[LS_RDY])
    else $error("data ready stuck after last character taken");

  cov_break: cover property (brk_hit);
  cov_overrun: cover property (ovr_evt);
  cov_ferr_read: cover property (ls_read && fifo_err);
  cov_irq: cover property (irq && int_mask[IS_THRE]);

endmodule : ulsr_line_status

// ===== tb/ulsr_far_model.sv
module ulsr_far_model
  import ulsr_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic clk_sys,        // system clock
  input  wire logic nrst,           // async reset, active low
  input  wire logic hold_write,     // host wrote a character
  input  wire logic fifo_mode,      // holding depth is DEPTH, else 1
  input  wire logic run,            // shifter may take characters
  input  wire logic slow,           // long shift time
  output logic      tx_shift_load,  // character taken into shifter
  output logic      tx_shift_done   // shifter empty again
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] held;
  logic [7:0] cap;
  logic       busy;
  logic [4:0] tmr;
  logic       take;
  assign cap  = fifo_mode ? 8'(DEPTH) : 8'h01;
  assign take = run && held != 8'h00 && !busy && !tx_shift_load;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      held          <= 8'h00;
      busy          <= 1'b0;
      tmr           <= 5'h00;
      tx_shift_load <= 1'b0;
      tx_shift_done <= 1'b0;
    end else begin
      held          <= held + 8'(hold_write && held < cap) - 8'(take);
      tx_shift_load <= take;
      tx_shift_done <= busy && tmr == 5'h00;
      if (take) begin
        busy <= 1'b1;
        tmr  <= slow ? 5'h13 : 5'h02;
      end else if (busy && tmr == 5'h00) begin
        busy <= 1'b0;
      end else if (busy) begin
        tmr <= tmr - 5'h01;
      end
    end
  end
endmodule : ulsr_far_model

// ===== tb/test_uart_line_status.sv
module test_uart_line_status
  import ulsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk_sys = 1'b0;
  logic               nrst = 1'b0;
  logic               hsel = 1'b0;
  logic [HADDR_W-1:0] haddr = '0;
  logic [1:0]         htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic [HDATA_W-1:0] hwdata = '0;
  wire logic          hready;
  logic               hreadyout;
  logic               hresp;
  logic [HDATA_W-1:0] hrdata;
  logic               rx_line = 1'b1;
  logic               rx_bit_tick = 1'b0;
  logic               rx_char_done = 1'b0;
  logic               rx_parity_bad = 1'b0;
  logic               rx_stop_level = 1'b1;
  logic               rx_pop = 1'b0;
  logic               rx_push;
  logic               rx_push_brk;
  logic               hold_write = 1'b0;
  logic               tx_shift_load;
  logic               tx_shift_done;
  logic               irq;
  logic               fm = 1'b0;
  logic               run = 1'b0;
  logic               slow = 1'b1;
  logic [31:0]        v;
  logic               p;
  logic               par;
  logic               st;
  logic [4:0]         ct;
  int                 miscompares = 0;
  int                 comparisons = 0;
  int                 cyc = 0;
  int                 n;
  int                 first;
  assign hready = hreadyout;
  always #20 clk_sys = ~clk_sys;
  ulsr_line_status #(.FIFO_DEPTH(2)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_line(rx_line),
    .rx_bit_tick(rx_bit_tick), .rx_char_done(rx_char_done),
    .rx_parity_bad(rx_parity_bad), .rx_stop_level(rx_stop_level), .rx_pop(rx_pop),
    .rx_push(rx_push), .rx_push_brk(rx_push_brk), .hold_write(hold_write),
    .tx_shift_load(tx_shift_load), .tx_shift_done(tx_shift_done), .irq(irq));
  ulsr_far_model #(.DEPTH(2)) far (
    .clk_sys(clk_sys), .nrst(nrst), .hold_write(hold_write), .fifo_mode(fm),
    .run(run), .slow(slow), .tx_shift_load(tx_shift_load),
    .tx_shift_done(tx_shift_done));
  task automatic conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] e);
    comparisons++;
    if (seen !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", w, e, seen);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     input logic tw, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel      <= 1'b1;
    htrans    <= HTRANS_NONSEQ;
    haddr     <= a;
    hwrite    <= wr;
    hold_write <= tw;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel      <= 1'b0;
    htrans    <= 2'h0;
    hwdata    <= wd;
    hold_write <= 1'b0;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", 32'(hresp), 32'(HRESP_OKAY));
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, 1'b0, x);
  endtask : wr
  task automatic rdchk(input string w, input logic [31:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, 1'b0, x);
    check(w, x & m, e);
  endtask : rdchk
  task automatic rx_char(input logic pb, input logic sl, output logic pushed);
    @(posedge clk_sys);
    rx_char_done  <= 1'b1;
    rx_parity_bad <= pb;
    rx_stop_level <= sl;
    #1 pushed = rx_push;
    @(posedge clk_sys);
    rx_char_done <= 1'b0;
  endtask : rx_char
  task automatic pop;
    @(posedge clk_sys);
    rx_pop <= 1'b1;
    @(posedge clk_sys);
    rx_pop <= 1'b0;
  endtask : pop
  task automatic irqchk(input string w, input logic e);
    repeat (3) @(posedge clk_sys);
    check(w, 32'(irq), 32'(e));
  endtask : irqchk
  // line status with transmitter idle
  function automatic logic [31:0] ls(input logic rdy, ovr, pe, fe, bk, er);
    return {24'h0, er, 2'b11, bk, fe, pe, ovr, rdy};
  endfunction : ls
  function automatic int frame_bits(input logic [4:0] ct);
    return 7 + int'(ct[2:1]) + int'(ct[3]) + int'(ct[4]);
  endfunction : frame_bits
  initial begin
    void'($urandom(32'h0a852b06));
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    rdchk("ls_reset", OFF_LSTAT, 32'hffffffff, 32'h60);
    wr(OFF_LSTAT, 32'hff);
    rdchk("ls_written", OFF_LSTAT, 32'hffffffff, 32'h60);
    rdchk("ctrl_reset", OFF_CTRL, 32'hffffffff, 32'h06);
    rdchk("imr_reset", OFF_IMR, 32'hffffffff, 32'h0);
    rdchk("isr_reset", OFF_ISR, 32'hffffffff, 32'h1);
    wr(32'h10, 32'hff);
    rdchk("unmapped", 32'h10, 32'hffffffff, 32'h0);
    rdchk("ctrl_kept", OFF_CTRL, 32'hffffffff, 32'h06);
    wr(OFF_IMR, 32'h1);
    irqchk("irq_thre", 1'b1);
    wr(OFF_IMR, 32'h2);
    irqchk("irq_masked", 1'b0);
    rx_char(1'b0, 1'b1, p);
    irqchk("irq_rx", 1'b1);
    wr(OFF_ISR, 32'h2);
    irqchk("irq_cleared", 1'b0);
    pop;
    wr(OFF_IMR, 32'h0);
    // holding stage write in the same cycle as the status read
    bus(1'b0, OFF_LSTAT, 32'h0, 1'b1, v);
    check("thre_drop", v & 32'h60, 32'h0);
    run <= 1'b1;
    do @(posedge clk_sys); while (tx_shift_load !== 1'b1);
    rdchk("thre_load", OFF_LSTAT, 32'h60, 32'h20);
    do @(posedge clk_sys); while (tx_shift_done !== 1'b1);
    rdchk("temt", OFF_LSTAT, 32'h60, 32'h60);
    run <= 1'b0;
    wr(OFF_CTRL, 32'h07);
    fm <= 1'b1;
    bus(1'b0, OFF_LSTAT, 32'h0, 1'b1, v);
    check("fifo_thre", v & 32'h60, 32'h0);
    bus(1'b1, 32'h10, 32'h0, 1'b1, v);
    run <= 1'b1;
    do @(posedge clk_sys); while (tx_shift_load !== 1'b1);
    rdchk("fifo_one_left", OFF_LSTAT, 32'h60, 32'h0);
    do @(posedge clk_sys); while (tx_shift_load !== 1'b1);
    rdchk("fifo_drained", OFF_LSTAT, 32'h60, 32'h20);
    do @(posedge clk_sys); while (tx_shift_done !== 1'b1);
    rdchk("fifo_temt", OFF_LSTAT, 32'h60, 32'h60);
    run  <= 1'b0;
    slow <= 1'b0;
    rx_char(1'b0, 1'b1, p);
    rx_char(1'b0, 1'b0, p);
    rdchk("head_ok", OFF_LSTAT, 32'hff, ls(1, 0, 0, 0, 0, 1));
    pop;
    rdchk("head_frm", OFF_LSTAT, 32'hff, ls(1, 0, 0, 1, 0, 0));
    pop;
    rdchk("rx_empty", OFF_LSTAT, 32'hff, ls(0, 0, 0, 0, 0, 0));
    repeat (3) rx_char(1'b0, 1'b1, p);
    check("ovr_push", 32'(p), 32'h0);
    rdchk("ovr_set", OFF_LSTAT, 32'hff, ls(1, 1, 0, 0, 0, 0));
    rdchk("ovr_clr", OFF_LSTAT, 32'hff, ls(1, 0, 0, 0, 0, 0));
    pop;
    rdchk("ovr_kept", OFF_LSTAT, 32'hff, ls(1, 0, 0, 0, 0, 0));
    pop;
    rdchk("ovr_empty", OFF_LSTAT, 32'hff, ls(0, 0, 0, 0, 0, 0));
    // break frame length drawn at random, fifo mode kept
    ct = {1'($urandom_range(1, 0)), 1'($urandom_range(1, 0)), 2'($urandom_range(3, 0)), 1'b1};
    wr(OFF_CTRL, 32'(ct));
    n     = 0;
    first = 0;
    @(posedge clk_sys);
    rx_line <= 1'b0;
    for (int i = 1; i <= 24; i++) begin
      @(posedge clk_sys);
      rx_bit_tick <= 1'b1;
      #1 if (rx_push_brk === 1'b1 && rx_push === 1'b1) begin
        n++;
        if (first == 0) first = i;
      end
      @(posedge clk_sys);
      rx_bit_tick <= 1'b0;
    end
    rx_line <= 1'b1;
    check("brk_tick", 32'(first), 32'(frame_bits(ct)));
    check("brk_count", 32'(n), 32'h1);
    rdchk("brk_ls", OFF_LSTAT, 32'hff, ls(1, 0, 0, 1, 1, 1));
    // reset in mid-run while the break character is still held
    nrst <= 1'b0;
    fm   <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rdchk("ls_rereset", OFF_LSTAT, 32'hffffffff, 32'h60);
    rdchk("ctrl_rereset", OFF_CTRL, 32'hffffffff, 32'h06);
    pop;
    wr(OFF_CTRL, 32'h06);
    repeat (8) begin
      par = 1'($urandom_range(1, 0));
      st  = 1'($urandom_range(1, 0));
      rx_char(par, st, p);
      check("rand_push", 32'(p), 32'h1);
      rdchk("rand_ls", OFF_LSTAT, 32'hff, ls(1, 0, par, !st, 0, par | !st));
      rdchk("rand_clr", OFF_LSTAT, 32'h80, 32'h0);
      pop;
    end
    conclude();
  end
endmodule : test_uart_line_status
